// file: src/ichr_channel.sv
/*
  One chronometer channel: input polarity, edge detection, divider,
  state machine, running count and held result.
  Assumes pins and configuration are synchronous to clk and ref_tick is a
  one-cycle pulse shared by all channels.
*/
`timescale 1ns/1ps
`default_nettype none
module ichr_channel
  import ichr_pkg::*;
(
  // clock and control
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic                  ref_tick,
  // configuration
  input  wire logic                  channel_enable,
  input  wire logic [MODE_W-1:0]     trigger_select,
  input  wire logic                  gating_enable,
  input  wire logic                  start_stop_polarity,
  input  wire logic                  stop_polarity,
  input  wire logic                  gate_invert,
  input  wire logic                  arm_flag,
  input  wire logic                  auto_return_flag,
  input  wire logic [DIV_W-1:0]      divider,
  // pins
  input  wire logic                  start_stop_pin,
  input  wire logic                  stop_pin,
  input  wire logic                  gate_pin,
  // results
  output logic [COUNT_W-1:0]         count_reg,   // running count [RULE_02]
  output logic [COUNT_W-1:0]         result_reg,  // held result, separate [RULE_02]
  output logic                       armed_reg,
  output logic                       counting_reg,
  output logic                       terminated_reg
);
  import ichr_pkg::*;

  ichr_state_t          state_reg, state_next;   // channel state
  logic                 ss_prev_reg, ss_prev_next;   // last start/stop level
  logic                 st_prev_reg, st_prev_next;   // last stop level
  logic [DIV_W-1:0]     div_reg, div_next;       // divider position
  logic [COUNT_W-1:0]   count_next, result_next;
  logic                 ss_lvl, st_lvl, gate_lvl;   // levels after inversion
  logic                 ss_rise, ss_fall, st_rise;
  logic                 stop_hit, pulse;

  // polarity applied before any edge or gating logic [RULE_06]
  assign ss_lvl   = start_stop_pin ^ start_stop_polarity;
  assign st_lvl   = stop_pin ^ stop_polarity;
  assign gate_lvl = gate_pin ^ gate_invert;
  assign ss_rise  = ss_lvl & ~ss_prev_reg;
  assign ss_fall  = ~ss_lvl & ss_prev_reg;
  assign st_rise  = st_lvl & ~st_prev_reg;

  // stop condition per trigger mode; reserved code never stops [RULE_05]
  always_comb begin
    case (trigger_select)
      MODE_LEVEL:    stop_hit = ss_fall;
      MODE_RISES:    stop_hit = ss_rise;
      MODE_STOP_PIN: stop_hit = st_rise;
      default:       stop_hit = 1'b0;
    endcase
  end

  // divided reference pulse: one pulse every divider+1 ticks [RULE_14]
  assign pulse = ref_tick && (div_reg == divider);

  // next state, count and result
  always_comb begin
    state_next   = state_reg;
    count_next   = count_reg;
    result_next  = result_reg;
    ss_prev_next = ss_lvl;
    st_prev_next = st_lvl;
    div_next     = div_reg;
    if (ref_tick) begin
      div_next = (div_reg >= divider) ? DIV_ZERO : div_reg + 1'b1;
    end
    if (!channel_enable) begin
      // disabled: inputs and pulses ignored, state, count, result and divider zeroed [RULE_07] [RULE_08]
      state_next  = ICHR_DISABLED;
      count_next  = COUNT_ZERO;
      result_next = COUNT_ZERO;
      div_next    = DIV_ZERO;
    end else begin
      case (state_reg)
        ICHR_DISABLED: state_next = ICHR_IDLE_WAITING; // [RULE_07]
        ICHR_IDLE_WAITING: begin
          if (arm_flag) state_next = ICHR_ARMED; // [RULE_09] [RULE_16]
        end
        ICHR_ARMED: begin
          count_next = COUNT_ZERO; // [RULE_10]
          div_next   = DIV_ZERO;
          // reserved mode holds here while it stays selected and the channel stays enabled [RULE_18]
          if (ss_rise && trigger_select != MODE_RESERVED) state_next = ICHR_COUNTING;
        end
        ICHR_COUNTING: begin
          // gate suspends pulse counting [RULE_11] [RULE_01]
          if (pulse && !(gating_enable && gate_lvl)) count_next = count_reg + 1'b1;
          if (stop_hit) begin
            state_next  = ICHR_TERMINATED; // [RULE_12]
            result_next = count_reg; // [RULE_03]
          end
        end
        ICHR_TERMINATED: begin
          if (auto_return_flag) state_next = ICHR_IDLE_WAITING; // [RULE_13]
        end
        default: state_next = ICHR_DISABLED;
      endcase
    end
  end

  // registers, frozen while ce is low [RULE_04]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= ICHR_DISABLED;
      count_reg      <= COUNT_ZERO;
      result_reg     <= COUNT_ZERO;
      ss_prev_reg    <= 1'b0;
      st_prev_reg    <= 1'b0;
      div_reg        <= DIV_ZERO;
      armed_reg      <= 1'b0;
      counting_reg   <= 1'b0;
      terminated_reg <= 1'b0;
    end else if (ce) begin
      state_reg      <= state_next;
      count_reg      <= count_next;
      result_reg     <= result_next;
      ss_prev_reg    <= ss_prev_next;
      st_prev_reg    <= st_prev_next;
      div_reg        <= div_next;
      armed_reg      <= (state_next == ICHR_ARMED); // [RULE_17]
      counting_reg   <= (state_next == ICHR_COUNTING);
      terminated_reg <= (state_next == ICHR_TERMINATED);
    end
  end

  // result only moves on entry to terminated or on disable
  result_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_03]
    (ce && channel_enable && state_reg != ICHR_COUNTING) |=> $stable(result_reg))
    else $error("result changed outside stop");
  disabled_zero_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_07]
    (ce && !channel_enable) |=> (count_reg == COUNT_ZERO && result_reg == COUNT_ZERO))
    else $error("disabled channel not zeroed");
  reserved_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_18]
    (state_reg == ICHR_ARMED && trigger_select == MODE_RESERVED && channel_enable) |=>
    state_reg == ICHR_ARMED)
    else $error("reserved mode left armed");
  arm_step_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_16]
    (ce && channel_enable && state_reg == ICHR_IDLE_WAITING && arm_flag) |=>
    state_reg == ICHR_ARMED)
    else $error("arm not taken");
  stop_term_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_12]
    (ce && channel_enable && state_reg == ICHR_COUNTING && stop_hit) |=>
    (state_reg == ICHR_TERMINATED && result_reg == $past(count_reg)))
    else $error("stop not handled");
  gate_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_11]
    (ce && channel_enable && state_reg == ICHR_COUNTING && gating_enable && gate_lvl) |=>
    $stable(count_reg))
    else $error("count moved while gated");
  armed_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_10]
    (ce && channel_enable && state_reg == ICHR_ARMED) |=> count_reg == COUNT_ZERO)
    else $error("armed count not cleared");
  status_flag_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_17]
    counting_reg == (state_reg == ICHR_COUNTING))
    else $error("counting flag wrong");
endmodule
`default_nettype wire

// file: src/ichr_pkg.sv
/*
  Constants and types shared by the interval chronometer: state encoding,
  trigger mode codes, widths and timing of the reference pulse.
  Assumes a single 100 MHz system clock; the reference pulse is derived from these constants in ichr_top.
*/
// How it works
// RULE_01: count 25 ns reference pulses for intervals
// RULE_02: separate 32-bit running count and result
// RULE_03: stop copies count into held result
// RULE_04: five states: disabled, idle, armed, counting, terminated
// RULE_05: 2-bit mode selects start/stop edges
// RULE_06: per-input inversion flags before edge detection
// RULE_07: enable low: disabled, count and result zero
// RULE_08: disabled channel ignores inputs and pulses
// RULE_09: idle waits until arm flag set
// RULE_10: armed clears count; rising start enters counting
// RULE_11: gate high with gating enabled suspends counting
// RULE_12: stop condition moves counting to terminated
// RULE_13: auto return flag goes back to idle
// RULE_14: divide reference by 30-bit divider plus one
// RULE_15: eight independent channels, numbered 0 to 7
// RULE_16: idle with arm set moves to armed
// RULE_17: armed, counting, terminated status flags
// RULE_18: reserved mode never starts, stays armed
package ichr_pkg;

  localparam int unsigned NUM_CHANNELS = 8;   // channels 0 to 7
  localparam int unsigned COUNT_W      = 32;  // running count and result width
  localparam int unsigned DIV_W        = 30;  // divider setting width
  localparam int unsigned MODE_W       = 2;   // trigger mode width

  // reference pulse period and the system clock it is derived from
  localparam int unsigned REF_PERIOD_NS = 25;
  localparam int unsigned CLK_PERIOD_PS = 10000;
  // half-clocks per reference period: 25 ns is 2.5 clocks, so 5
  localparam int unsigned REF_HALF_CLKS = (REF_PERIOD_NS * 2000) / CLK_PERIOD_PS;

  // fractional accumulator step: add 2 per clock, pulse every 5 (= 2.5 clocks)
  localparam logic [2:0] ACC_STEP  = 3'h2;
  localparam logic [2:0] ACC_LIMIT = 3'(REF_HALF_CLKS);
  localparam logic [2:0] ACC_ZERO  = 3'h0; // phase after reset

  // trigger mode codes
  localparam logic [MODE_W-1:0] MODE_LEVEL    = 2'h0; // rise start, fall stop
  localparam logic [MODE_W-1:0] MODE_RISES    = 2'h1; // rise start, rise stop
  localparam logic [MODE_W-1:0] MODE_STOP_PIN = 2'h2; // rise start, stop pin
  localparam logic [MODE_W-1:0] MODE_RESERVED = 2'h3; // unused code, never starts

  localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [DIV_W-1:0]   DIV_ZERO   = 30'h0000_0000;

  typedef enum logic [2:0] {
    ICHR_DISABLED,
    ICHR_IDLE_WAITING,
    ICHR_ARMED,
    ICHR_COUNTING,
    ICHR_TERMINATED
  } ichr_state_t;

endpackage

// file: src/ichr_top.sv
/*
  Eight-channel interval chronometer with a shared 25 ns reference pulse.
  Assumes configuration ports are held by the host and pins are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module ichr_top
  import ichr_pkg::*;
(
  // clock and control
  input  wire logic                                 clk,
  input  wire logic                                 resetn,
  input  wire logic                                 ce,
  // per-channel configuration, bit or field n for channel n
  input  wire logic [NUM_CHANNELS-1:0]              channel_enable,
  input  wire logic [NUM_CHANNELS-1:0][MODE_W-1:0]  trigger_select,
  input  wire logic [NUM_CHANNELS-1:0]              gating_enable,
  input  wire logic [NUM_CHANNELS-1:0]              start_stop_polarity,
  input  wire logic [NUM_CHANNELS-1:0]              stop_polarity,
  input  wire logic [NUM_CHANNELS-1:0]              gate_invert,
  input  wire logic [NUM_CHANNELS-1:0]              arm_flag,
  input  wire logic [NUM_CHANNELS-1:0]              auto_return_flag,
  input  wire logic [NUM_CHANNELS-1:0][DIV_W-1:0]   divider,
  // pins
  input  wire logic [NUM_CHANNELS-1:0]              start_stop_pin,
  input  wire logic [NUM_CHANNELS-1:0]              stop_pin,
  input  wire logic [NUM_CHANNELS-1:0]              gate_pin,
  // status
  output logic [NUM_CHANNELS-1:0][COUNT_W-1:0]      count,
  output logic [NUM_CHANNELS-1:0][COUNT_W-1:0]      result,
  output logic [NUM_CHANNELS-1:0]                   armed,
  output logic [NUM_CHANNELS-1:0]                   counting,
  output logic [NUM_CHANNELS-1:0]                   terminated
);
  import ichr_pkg::*;

  logic [2:0] acc_reg, acc_next;   // fractional phase of the reference
  logic       tick_reg, tick_next; // one-cycle reference pulse

  // 25 ns is 2.5 clocks: a modulo-5 phase stepped by 2 wraps twice per
  // 5 clocks, so pulses average every 2.5 clocks with 10 ns jitter [RULE_01]
  always_comb begin
    if (acc_reg + ACC_STEP >= ACC_LIMIT) begin
      acc_next  = acc_reg + ACC_STEP - ACC_LIMIT;
      tick_next = 1'b1;
    end else begin
      acc_next  = acc_reg + ACC_STEP;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg  <= ACC_ZERO;
      tick_reg <= 1'b0;
    end else if (ce) begin
      acc_reg  <= acc_next;
      tick_reg <= tick_next;
    end
  end

  // eight independent channels [RULE_15]
  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : g_ch
      ichr_channel u_ch (
        .clk                 (clk),
        .resetn              (resetn),
        .ce                  (ce),
        .ref_tick            (tick_reg & ce),
        .channel_enable      (channel_enable[g]),
        .trigger_select      (trigger_select[g]),
        .gating_enable       (gating_enable[g]),
        .start_stop_polarity (start_stop_polarity[g]),
        .stop_polarity       (stop_polarity[g]),
        .gate_invert         (gate_invert[g]),
        .arm_flag            (arm_flag[g]),
        .auto_return_flag    (auto_return_flag[g]),
        .divider             (divider[g]),
        .start_stop_pin      (start_stop_pin[g]),
        .stop_pin            (stop_pin[g]),
        .gate_pin            (gate_pin[g]),
        .count_reg           (count[g]),
        .result_reg          (result[g]),
        .armed_reg           (armed[g]),
        .counting_reg        (counting[g]),
        .terminated_reg      (terminated[g])
      );
    end
  endgenerate

  tick_rate_a: assert property (@(posedge clk) disable iff (!resetn) // [RULE_01]
    (ce && tick_reg) |=> !tick_reg)
    else $error("reference pulses too close");
endmodule
`default_nettype wire

// file: bench/ichr_pins.sv
/*
  Model of the external start/stop, stop and gate signals of all channels.
  Assumes the caller changes levels at the falling edge of the bench clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ichr_pins (
  // pin levels seen by the chronometer
  output var logic [7:0] start_stop_pin,
  output var logic [7:0] stop_pin,
  output var logic [7:0] gate_pin
);
  // all lines start low, so no edge is seen before a test asks for one
  initial begin
    start_stop_pin = 8'h00;
    stop_pin       = 8'h00;
    gate_pin       = 8'h00;
  end
  // set the three digital levels of one channel at once
  task automatic set(input int ch, input logic s, input logic t, input logic g);
    start_stop_pin[ch] = s;
    stop_pin[ch]       = t;
    gate_pin[ch]       = g;
  endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
/*
  Self-checking bench of the eight-channel chronometer.
  Assumes ichr_pkg and the design files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ichr_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] en = '0, gen = '0, ssp = '0, stp = '0, gti = '0, arm = '0, aut = '0;
  logic [7:0][MODE_W-1:0] mode = '0;
  logic [7:0][DIV_W-1:0]  div = '0;
  wire logic [7:0] ss, sp, gp;
  logic [7:0][COUNT_W-1:0] cnt, res;
  logic [7:0] armd, cntg, term;
  logic [31:0] r;
  int miscompares = 0;
  int n_checks = 0;
  ichr_pins pins_u (.start_stop_pin(ss), .stop_pin(sp), .gate_pin(gp));
  // ce is driven so that the freeze of a running count and its counting flag can be checked once
  ichr_top dut_u (.clk(clk), .resetn(resetn), .ce(ce), .channel_enable(en),
    .trigger_select(mode), .gating_enable(gen), .start_stop_polarity(ssp),
    .stop_polarity(stp), .gate_invert(gti), .arm_flag(arm), .auto_return_flag(aut),
    .divider(div), .start_stop_pin(ss), .stop_pin(sp), .gate_pin(gp), .count(cnt),
    .result(res), .armed(armd), .counting(cntg), .terminated(term));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic summarize;
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // bounded wait for a state flag: 0 armed, 1 counting, 2 terminated
  task automatic wait_bit(input int ch, input int w);
    logic b;
    b = 1'b0;
    for (int i = 0; i < 20 && b !== 1'b1; i++) begin
      @(negedge clk);
      b = (w == 0) ? armd[ch] : (w == 1) ? cntg[ch] : term[ch];
    end
    check("state flag", b, 1'b1);
  endtask
  // one full measurement; pol inverts both start/stop and stop lines
  task automatic meas(input int ch, input logic [1:0] m, input logic pol, input int hold,
                      input logic g);
    @(negedge clk);
    en[ch] = 1'b0;
    arm[ch] = 1'b0;
    mode[ch] = m;
    ssp[ch] = pol;
    stp[ch] = pol;
    pins_u.set(ch, pol, pol, g);
    repeat (3) @(negedge clk);
    check("count off", cnt[ch], 32'h0);
    check("result off", res[ch], 32'h0);
    en[ch] = 1'b1;
    repeat (4) @(negedge clk);
    check("armed idle", armd[ch], 1'b0);
    arm[ch] = 1'b1;
    wait_bit(ch, 0);
    pins_u.set(ch, ~pol, pol, g);
    wait_bit(ch, 1);
    repeat (hold) @(negedge clk);
    check("result held", res[ch], 32'h0);
    pins_u.set(ch, pol, pol, g);
    if (m != MODE_LEVEL) begin
      repeat (3) @(negedge clk);
      check("still counting", cntg[ch], 1'b1);
      if (m == MODE_RISES) pins_u.set(ch, ~pol, pol, g);
      else pins_u.set(ch, pol, ~pol, g);
    end
    wait_bit(ch, 2);
    check("not counting", cntg[ch], 1'b0);
    r = res[ch];
    repeat (5) @(negedge clk);
    check("result stable", res[ch], r);
  endtask
  task automatic in_range(input logic [31:0] lo, input logic [31:0] hi);
    check("result range", (r >= lo && r <= hi), 1'b1);
  endtask
  // watchdog, about fifteen times the expected run
  initial begin
    #200us;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    check("flags after reset", {armd, cntg, term}, 24'h0);
    // disabled channel ignores arm and pin edges
    arm[0] = 1'b1;
    pins_u.set(0, 1'b1, 1'b1, 1'b0);
    repeat (10) @(negedge clk);
    check("disabled counting", cntg[0], 1'b0);
    check("disabled armed", armd[0], 1'b0);
    check("disabled count", cnt[0], 32'h0);
    // the three counting modes with and without inversion, one channel each
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 2; p++) begin
        meas(m * 2 + p, m[1:0], p[0], 100, 1'b0);
        in_range(39, 46);
      end
    end
    // divide by five
    div[6] = 30'h0000_0004;
    meas(6, MODE_LEVEL, 1'b0, 200, 1'b0);
    in_range(14, 19);
    // gate active suspends counting, ignored when gating is off
    gen[7] = 1'b1;
    meas(7, MODE_LEVEL, 1'b0, 100, 1'b1);
    check("gated", r, 32'h0);
    gti[7] = 1'b1;
    meas(7, MODE_LEVEL, 1'b0, 100, 1'b1);
    in_range(39, 46);
    gti[7] = 1'b0;
    gen[7] = 1'b0;
    meas(7, MODE_LEVEL, 1'b0, 100, 1'b1);
    in_range(39, 46);
    // auto return with arm still set rearms
    aut[1] = 1'b1;
    wait_bit(1, 0);
    @(negedge clk);
    check("armed clear", cnt[1], 32'h0);
    // ce low freezes a running count, which resumes once ce returns
    pins_u.set(1, 1'b0, 1'b1, 1'b0);
    wait_bit(1, 1);
    repeat (10) @(negedge clk);
    ce = 1'b0;
    r = cnt[1];
    repeat (10) @(negedge clk);
    check("frozen count", cnt[1], r);
    check("frozen state", cntg[1], 1'b1);
    ce = 1'b1;
    repeat (10) @(negedge clk);
    check("count resumes", (cnt[1] > r), 1'b1);
    // reserved mode never starts
    en[0] = 1'b0;
    mode[0] = 2'h3;
    pins_u.set(0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(negedge clk);
    en[0] = 1'b1;
    wait_bit(0, 0);
    pins_u.set(0, 1'b1, 1'b1, 1'b0);
    repeat (10) @(negedge clk);
    check("reserved", {armd[0], cntg[0]}, 2'h2);
    summarize();
  end
endmodule
`default_nettype wire
